// *** comparator_cfg_pkg.sv ***
package comparator_cfg_pkg;

    // register addresses on page zero
    localparam logic [7:0] SFR_PAGE_ZERO        = 8'h00;
    localparam logic [7:0] ADDR_COMP_B_MODE     = 8'h9C;
    localparam logic [7:0] ADDR_COMP_A_INSEL    = 8'h9F;
    localparam logic [7:0] ADDR_COMP_B_INSEL    = 8'h9E;
    localparam logic [7:0] ADDR_COMP_A_CTRL     = 8'h9B;
    localparam logic [7:0] ADDR_COMP_B_CTRL     = 8'h9A;

    // mode register fields
    localparam int         MODE_RSVD_BIT        = 7;
    localparam int         MODE_UNUSED_BIT      = 6;
    localparam int         MODE_RISE_IE_BIT     = 5;
    localparam int         MODE_FALL_IE_BIT     = 4;
    localparam int         MODE_RESP_LSB        = 0;
    localparam logic [7:0] MODE_RESET           = 8'h82;
    localparam logic [7:0] MODE_WRITE_MASK      = 8'h33;
    localparam logic [7:0] MODE_FORCE_ONES      = 8'h80;

    // control register fields
    localparam int         CTRL_EN_BIT          = 7;
    localparam int         CTRL_OUT_BIT         = 6;
    localparam int         CTRL_RISE_BIT        = 5;
    localparam int         CTRL_FALL_BIT        = 4;
    localparam logic [7:0] CTRL_RESET           = 8'h00;
    localparam logic [7:0] CTRL_WRITE_MASK      = 8'hBF;

    // input select fields and codes
    localparam int         SEL_NEG_LSB          = 4;
    localparam int         SEL_POS_LSB          = 0;
    localparam logic [7:0] INSEL_RESET          = 8'hFF;
    localparam logic [3:0] CODE_NEG_LAST_PORT2  = 4'hA;
    localparam logic [3:0] CODE_POS_LAST_PORT2  = 4'hB;
    localparam logic [3:0] CODE_RESERVED        = 4'hB;
    localparam logic [3:0] CODE_TOUCH           = 4'hC;
    localparam logic [3:0] CODE_HALF_SUPPLY     = 4'hD;
    localparam logic [3:0] CODE_SUPPLY_A        = 4'hE;
    localparam logic [3:0] CODE_SUPPLY_B        = 4'hF;

    // number of port pin sources on the positive mux (the negative mux has 11)
    localparam int         NUM_PIN_SRC          = 12;

endpackage

// *** comp_input_mux_decode.sv ***
`timescale 1ns/10ps
`default_nettype none

// turns one 4-bit select code into one-hot analog switch controls
module comp_input_mux_decode #(
    parameter logic       IS_POSITIVE = 1'b1
) (
    input  wire logic [3:0]  sel_code,
    input  wire logic        comp_enable,
    output logic [11:0] pin_switch,
    output logic        touch_switch,
    output logic        half_supply_switch,
    output logic        supply_a_switch,
    output logic        supply_b_switch
);

    wire logic [3:0] last_pin_code;
    wire logic       code_is_pin;
    wire logic       code_reserved;

    assign last_pin_code = IS_POSITIVE ? comparator_cfg_pkg::CODE_POS_LAST_PORT2
                                       : comparator_cfg_pkg::CODE_NEG_LAST_PORT2;
    assign code_is_pin   = (sel_code <= last_pin_code);
    // negative mux has no pin at code 1011, positive mux does
    assign code_reserved = !IS_POSITIVE && (sel_code == comparator_cfg_pkg::CODE_RESERVED);

    genvar i;
    generate
        for (i = 0; i < comparator_cfg_pkg::NUM_PIN_SRC; i = i + 1)
        begin : g_pin
            assign pin_switch[i] = comp_enable && code_is_pin && !code_reserved
                                   && (sel_code == 4'(i));
        end
    endgenerate

    assign touch_switch       = comp_enable && (sel_code == comparator_cfg_pkg::CODE_TOUCH);
    assign half_supply_switch = comp_enable && (sel_code == comparator_cfg_pkg::CODE_HALF_SUPPLY);
    assign supply_a_switch    = comp_enable && (sel_code == comparator_cfg_pkg::CODE_SUPPLY_A);
    assign supply_b_switch    = comp_enable && (sel_code == comparator_cfg_pkg::CODE_SUPPLY_B);

endmodule // comp_input_mux_decode

`default_nettype wire

// *** comparator_mode_and_input_select.sv ***
`timescale 1ns/10ps
`default_nettype none

module comparator_mode_and_input_select (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_page,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]  sfr_rdata,
    input  wire logic        comp_a_raw_out,
    input  wire logic        comp_b_raw_out,
    output logic        comp_a_power_on,
    output logic        comp_b_power_on,
    output logic [1:0]  comp_b_response_mode,
    output logic [11:0] comp_a_positive_mux,
    output logic [11:0] comp_a_negative_mux,
    output logic [3:0]  comp_a_pos_internal,
    output logic [3:0]  comp_a_neg_internal,
    output logic [11:0] comp_b_positive_mux,
    output logic [11:0] comp_b_negative_mux,
    output logic [3:0]  comp_b_pos_internal,
    output logic [3:0]  comp_b_neg_internal,
    output logic        half_supply_divider_on,
    output logic        touch_sense_a_active,
    output logic        touch_sense_b_active,
    output logic        timer_capture_a,
    output logic        timer_capture_b,
    output logic        comp_b_irq
);

    logic [7:0] comparator_b_mode_control_r;
    logic [7:0] comparator_a_input_select_r;
    logic [7:0] comparator_b_input_select_r;
    logic [7:0] comp_a_ctrl_r;
    logic [7:0] comp_b_ctrl_r;
    logic [1:0] sync_a_r;
    logic [1:0] sync_b_r;
    logic       prev_a_r;
    logic       prev_b_r;

    wire logic page0;
    wire logic sel_mode_b;
    wire logic sel_insel_a;
    wire logic sel_insel_b;
    wire logic sel_ctrl_a;
    wire logic sel_ctrl_b;
    assign page0       = (sfr_page == comparator_cfg_pkg::SFR_PAGE_ZERO);
    assign sel_mode_b  = page0 && (sfr_addr == comparator_cfg_pkg::ADDR_COMP_B_MODE);
    assign sel_insel_a = page0 && (sfr_addr == comparator_cfg_pkg::ADDR_COMP_A_INSEL);
    assign sel_insel_b = page0 && (sfr_addr == comparator_cfg_pkg::ADDR_COMP_B_INSEL);
    assign sel_ctrl_a  = page0 && (sfr_addr == comparator_cfg_pkg::ADDR_COMP_A_CTRL);
    assign sel_ctrl_b  = page0 && (sfr_addr == comparator_cfg_pkg::ADDR_COMP_B_CTRL);

    // comparator outputs are asynchronous to ref_clk
    wire logic out_a;
    wire logic out_b;
    assign out_a = sync_a_r[1];
    assign out_b = sync_b_r[1];

    wire logic en_a;
    wire logic en_b;
    assign en_a = comp_a_ctrl_r[comparator_cfg_pkg::CTRL_EN_BIT];
    assign en_b = comp_b_ctrl_r[comparator_cfg_pkg::CTRL_EN_BIT];

    // edges only count while enabled, so power-up glitches of a disabled part are dropped
    wire logic rise_a;
    wire logic fall_a;
    wire logic rise_b;
    wire logic fall_b;
    assign rise_a = en_a && out_a && !prev_a_r;
    assign fall_a = en_a && !out_a && prev_a_r;
    assign rise_b = en_b && out_b && !prev_b_r;
    assign fall_b = en_b && !out_b && prev_b_r;

    // write mask leaves reserved and unused bits untouched
    wire logic [7:0] mode_b_nxt;
    assign mode_b_nxt = (sfr_wdata & comparator_cfg_pkg::MODE_WRITE_MASK)
                        | comparator_cfg_pkg::MODE_FORCE_ONES;

    // set wins over a software clear in the same cycle
    function automatic logic [7:0] ctrl_next(input logic [7:0] cur, input logic wr,
                                             input logic [7:0] wd, input logic rise,
                                             input logic fall, input logic outv);
        logic [7:0] v;
        v = wr ? (wd & comparator_cfg_pkg::CTRL_WRITE_MASK) : cur;
        v[comparator_cfg_pkg::CTRL_OUT_BIT]  = outv;
        v[comparator_cfg_pkg::CTRL_RISE_BIT] = v[comparator_cfg_pkg::CTRL_RISE_BIT] | rise;
        v[comparator_cfg_pkg::CTRL_FALL_BIT] = v[comparator_cfg_pkg::CTRL_FALL_BIT] | fall;
        return v;
    endfunction

    wire logic [7:0] ctrl_a_nxt;
    wire logic [7:0] ctrl_b_nxt;
    assign ctrl_a_nxt = ctrl_next(comp_a_ctrl_r, sfr_wr && sel_ctrl_a, sfr_wdata,
                                  rise_a, fall_a, out_a);
    assign ctrl_b_nxt = ctrl_next(comp_b_ctrl_r, sfr_wr && sel_ctrl_b, sfr_wdata,
                                  rise_b, fall_b, out_b);

    wire logic [7:0] rdata_nxt;
    assign rdata_nxt = !sfr_rd     ? sfr_rdata :
                       sel_mode_b  ? comparator_b_mode_control_r :
                       sel_insel_a ? comparator_a_input_select_r :
                       sel_insel_b ? comparator_b_input_select_r :
                       sel_ctrl_a  ? comp_a_ctrl_r :
                       sel_ctrl_b  ? comp_b_ctrl_r : 8'h00;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            comparator_b_mode_control_r <= comparator_cfg_pkg::MODE_RESET;
            comparator_a_input_select_r <= comparator_cfg_pkg::INSEL_RESET;
            comparator_b_input_select_r <= comparator_cfg_pkg::INSEL_RESET;
            comp_a_ctrl_r               <= comparator_cfg_pkg::CTRL_RESET;
            comp_b_ctrl_r               <= comparator_cfg_pkg::CTRL_RESET;
            sync_a_r                    <= 2'h0;
            sync_b_r                    <= 2'h0;
            prev_a_r                    <= 1'b0;
            prev_b_r                    <= 1'b0;
            sfr_rdata                   <= 8'h00;
        end
        else
        begin
            if (sfr_wr && sel_mode_b)
                comparator_b_mode_control_r <= mode_b_nxt;
            if (sfr_wr && sel_insel_a)
                comparator_a_input_select_r <= sfr_wdata;
            if (sfr_wr && sel_insel_b)
                comparator_b_input_select_r <= sfr_wdata;
            comp_a_ctrl_r <= ctrl_a_nxt;
            comp_b_ctrl_r <= ctrl_b_nxt;
            sync_a_r      <= {sync_a_r[0], comp_a_raw_out};
            sync_b_r      <= {sync_b_r[0], comp_b_raw_out};
            prev_a_r      <= out_a;
            prev_b_r      <= out_b;
            sfr_rdata     <= rdata_nxt;
        end
    end

    // mux switch decode, one instance per mux
    wire logic [11:0] a_pos_pins;
    wire logic [11:0] a_neg_pins;
    wire logic [11:0] b_pos_pins;
    wire logic [11:0] b_neg_pins;
    wire logic [3:0]  a_pos_int;
    wire logic [3:0]  a_neg_int;
    wire logic [3:0]  b_pos_int;
    wire logic [3:0]  b_neg_int;

    comp_input_mux_decode #(.IS_POSITIVE(1'b1)) u_a_pos (
        .sel_code           (comparator_a_input_select_r[comparator_cfg_pkg::SEL_POS_LSB +: 4]),
        .comp_enable        (en_a),
        .pin_switch         (a_pos_pins),
        .touch_switch       (a_pos_int[0]),
        .half_supply_switch (a_pos_int[1]),
        .supply_a_switch    (a_pos_int[2]),
        .supply_b_switch    (a_pos_int[3])
    );
    comp_input_mux_decode #(.IS_POSITIVE(1'b0)) u_a_neg (
        .sel_code           (comparator_a_input_select_r[comparator_cfg_pkg::SEL_NEG_LSB +: 4]),
        .comp_enable        (en_a),
        .pin_switch         (a_neg_pins),
        .touch_switch       (a_neg_int[0]),
        .half_supply_switch (a_neg_int[1]),
        .supply_a_switch    (a_neg_int[2]),
        .supply_b_switch    (a_neg_int[3])
    );
    comp_input_mux_decode #(.IS_POSITIVE(1'b1)) u_b_pos (
        .sel_code           (comparator_b_input_select_r[comparator_cfg_pkg::SEL_POS_LSB +: 4]),
        .comp_enable        (en_b),
        .pin_switch         (b_pos_pins),
        .touch_switch       (b_pos_int[0]),
        .half_supply_switch (b_pos_int[1]),
        .supply_a_switch    (b_pos_int[2]),
        .supply_b_switch    (b_pos_int[3])
    );
    comp_input_mux_decode #(.IS_POSITIVE(1'b0)) u_b_neg (
        .sel_code           (comparator_b_input_select_r[comparator_cfg_pkg::SEL_NEG_LSB +: 4]),
        .comp_enable        (en_b),
        .pin_switch         (b_neg_pins),
        .touch_switch       (b_neg_int[0]),
        .half_supply_switch (b_neg_int[1]),
        .supply_a_switch    (b_neg_int[2]),
        .supply_b_switch    (b_neg_int[3])
    );

    // divider draws current, so it is gated to the one code that needs it
    wire logic divider_nxt;
    assign divider_nxt = a_pos_int[1] | a_neg_int[1] | b_pos_int[1] | b_neg_int[1];

    wire logic touch_a_nxt;
    wire logic touch_b_nxt;
    assign touch_a_nxt = (a_pos_int[0] && (|a_neg_pins))
                         || (a_neg_int[0] && (|a_pos_pins));
    assign touch_b_nxt = (b_pos_int[0] && (|b_neg_pins))
                         || (b_neg_int[0] && (|b_pos_pins));

    wire logic irq_nxt;
    assign irq_nxt = (comp_b_ctrl_r[comparator_cfg_pkg::CTRL_RISE_BIT]
                      && comparator_b_mode_control_r[comparator_cfg_pkg::MODE_RISE_IE_BIT])
                     || (comp_b_ctrl_r[comparator_cfg_pkg::CTRL_FALL_BIT]
                      && comparator_b_mode_control_r[comparator_cfg_pkg::MODE_FALL_IE_BIT]);

    // analog controls are registered; one cycle lag is harmless against analog settling
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            comp_a_power_on        <= 1'b0;
            comp_b_power_on        <= 1'b0;
            comp_b_response_mode   <= 2'h2;
            comp_a_positive_mux    <= 12'h000;
            comp_a_negative_mux    <= 12'h000;
            comp_a_pos_internal    <= 4'h0;
            comp_a_neg_internal    <= 4'h0;
            comp_b_positive_mux    <= 12'h000;
            comp_b_negative_mux    <= 12'h000;
            comp_b_pos_internal    <= 4'h0;
            comp_b_neg_internal    <= 4'h0;
            half_supply_divider_on <= 1'b0;
            touch_sense_a_active   <= 1'b0;
            touch_sense_b_active   <= 1'b0;
            timer_capture_a        <= 1'b0;
            timer_capture_b        <= 1'b0;
            comp_b_irq             <= 1'b0;
        end
        else
        begin
            comp_a_power_on        <= en_a;
            comp_b_power_on        <= en_b;
            comp_b_response_mode   <= comparator_b_mode_control_r[comparator_cfg_pkg::MODE_RESP_LSB +: 2];
            comp_a_positive_mux    <= a_pos_pins;
            comp_a_negative_mux    <= a_neg_pins;
            comp_a_pos_internal    <= a_pos_int;
            comp_a_neg_internal    <= a_neg_int;
            comp_b_positive_mux    <= b_pos_pins;
            comp_b_negative_mux    <= b_neg_pins;
            comp_b_pos_internal    <= b_pos_int;
            comp_b_neg_internal    <= b_neg_int;
            half_supply_divider_on <= divider_nxt;
            touch_sense_a_active   <= touch_a_nxt;
            touch_sense_b_active   <= touch_b_nxt;
            timer_capture_a        <= en_a && out_a;
            timer_capture_b        <= en_b && out_b;
            comp_b_irq             <= irq_nxt;
        end
    end

endmodule // comparator_mode_and_input_select

`default_nettype wire

// *** comparator_cfg_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module comparator_cfg_props (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_page,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        comp_a_raw_out,
    input wire logic        comp_a_power_on,
    input wire logic [1:0]  comp_b_response_mode,
    input wire logic [11:0] comp_a_positive_mux,
    input wire logic [11:0] comp_a_negative_mux,
    input wire logic [3:0]  comp_a_pos_internal,
    input wire logic [3:0]  comp_a_neg_internal,
    input wire logic [11:0] comp_b_negative_mux,
    input wire logic [3:0]  comp_b_pos_internal,
    input wire logic [3:0]  comp_b_neg_internal,
    input wire logic        half_supply_divider_on,
    input wire logic        timer_capture_a,
    input wire logic        comp_b_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic pg0  = sfr_page == comparator_cfg_pkg::SFR_PAGE_ZERO;
    wire logic wr_m = sfr_wr && pg0 && sfr_addr == comparator_cfg_pkg::ADDR_COMP_B_MODE;
    wire logic rd_m = sfr_rd && pg0 && sfr_addr == comparator_cfg_pkg::ADDR_COMP_B_MODE;
    wire logic wr_a = sfr_wr && pg0 && sfr_addr == comparator_cfg_pkg::ADDR_COMP_A_INSEL;
    wire logic rd_a = sfr_rd && pg0 && sfr_addr == comparator_cfg_pkg::ADDR_COMP_A_INSEL;
    // last value software wrote, so readback can be checked at any distance from the write
    logic [7:0] last_mode_r;
    logic [7:0] last_insel_r;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            last_mode_r  <= comparator_cfg_pkg::MODE_RESET;
            last_insel_r <= comparator_cfg_pkg::INSEL_RESET;
        end
        else
        begin
            if (wr_m)
                last_mode_r <= sfr_wdata;
            if (wr_a)
                last_insel_r <= sfr_wdata;
        end
    end
    wire logic [3:0] half_v = {comp_a_pos_internal[1], comp_a_neg_internal[1],
                               comp_b_pos_internal[1], comp_b_neg_internal[1]};
    property p_reset_out;
        $fell(rst) |-> comp_b_response_mode == 2'h2 && !comp_b_irq && !half_supply_divider_on;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
    property p_resp;
        wr_m |-> ##2 comp_b_response_mode == $past(sfr_wdata[1:0], 2);
    endproperty
    a_resp: assert property (p_resp) else $error("response mode not taken");
    property p_mode_fixed;
        rd_m |=> sfr_rdata[7] && !sfr_rdata[6] && sfr_rdata[3:2] == 2'h0;
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("fixed mode bits wrong");
    property p_mode_rb;
        rd_m && !wr_m |=> sfr_rdata[5:4] == $past(last_mode_r[5:4]);
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("edge enables not stored");
    property p_insel_rb;
        rd_a && !wr_a |=> sfr_rdata == $past(last_insel_r);
    endproperty
    a_insel_rb: assert property (p_insel_rb) else $error("input select not stored");
    property p_refuse;
        sfr_rd && !pg0 |=> sfr_rdata == 8'h00;
    endproperty
    a_refuse: assert property (p_refuse) else $error("other page read not zero");
    property p_half;
        half_supply_divider_on == (half_v != 4'h0);
    endproperty
    a_half: assert property (p_half) else $error("divider state wrong");
    property p_onehot;
        $onehot0({comp_a_positive_mux, comp_a_pos_internal})
            && $onehot0({comp_a_negative_mux, comp_a_neg_internal});
    endproperty
    a_onehot: assert property (p_onehot) else $error("mux has two sources");
    property p_rsvd;
        !comp_a_negative_mux[11] && !comp_b_negative_mux[11];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved switch closed");
    property p_off;
        !comp_a_power_on |-> comp_a_positive_mux == 12'h000 && comp_a_neg_internal == 4'h0
            && !timer_capture_a;
    endproperty
    a_off: assert property (p_off) else $error("disabled comparator active");
    property p_capture;
        (comp_a_power_on && $stable(comp_a_raw_out))[*5] |-> timer_capture_a == comp_a_raw_out;
    endproperty
    a_capture: assert property (p_capture) else $error("capture source stale");
    c_slow: cover property (wr_m ##2 comp_b_response_mode == 2'h3);
    c_half: cover property (half_supply_divider_on);
    c_irq: cover property (comp_b_irq);
endmodule // comparator_cfg_props
bind comparator_mode_and_input_select comparator_cfg_props u_comparator_cfg_props (
    .ref_clk, .rst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .comp_a_raw_out, .comp_a_power_on, .comp_b_response_mode, .comp_a_positive_mux,
    .comp_a_negative_mux, .comp_a_pos_internal, .comp_a_neg_internal, .comp_b_negative_mux,
    .comp_b_pos_internal, .comp_b_neg_internal, .half_supply_divider_on, .timer_capture_a,
    .comp_b_irq);
`default_nettype wire

// *** comparator_mode_and_input_select_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module comparator_mode_and_input_select_bench;
    logic        ref_clk, rst, sfr_wr, sfr_rd, comp_a_raw_out, comp_b_raw_out;
    logic [7:0]  sfr_addr, sfr_page, sfr_wdata, sfr_rdata, d, mode_m;
    logic        a_on, b_on, half_on, touch_a, touch_b, cap_a, cap_b, irq_b;
    logic [1:0]  resp;
    logic [11:0] pm[2], nm[2];
    logic [3:0]  pi[2], ni[2];
    int          err_count, compares, cycles, p, n;
    comparator_mode_and_input_select u_comparator_mode_and_input_select (
        .ref_clk, .rst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .comp_a_raw_out, .comp_b_raw_out, .comp_a_power_on(a_on), .comp_b_power_on(b_on),
        .comp_b_response_mode(resp), .comp_a_positive_mux(pm[0]),
        .comp_a_negative_mux(nm[0]), .comp_a_pos_internal(pi[0]),
        .comp_a_neg_internal(ni[0]), .comp_b_positive_mux(pm[1]),
        .comp_b_negative_mux(nm[1]), .comp_b_pos_internal(pi[1]),
        .comp_b_neg_internal(ni[1]), .half_supply_divider_on(half_on),
        .touch_sense_a_active(touch_a), .touch_sense_b_active(touch_b),
        .timer_capture_a(cap_a), .timer_capture_b(cap_b), .comp_b_irq(irq_b));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int cnt);
        repeat (cnt) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] pg = 8'h00);
        @(posedge ref_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_page <= pg;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] pg = 8'h00);
        @(posedge ref_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        sfr_page <= pg;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1;
        chk("read data", {8'h00, exp}, {8'h00, sfr_rdata});
    endtask
    // selected source as {pin switches, internal switches}; negative 1011 connects nothing
    function automatic logic [15:0] mux_exp(input int c, input bit neg);
        if (neg && c == 11)
            return 16'h0000;
        return (c < 12) ? {12'h001 << c, 4'h0} : {12'h000, 4'h1 << (c - 12)};
    endfunction
    initial
    begin
        {ref_clk, sfr_wr, sfr_rd, comp_a_raw_out, comp_b_raw_out} = '0;
        {sfr_addr, sfr_page, sfr_wdata} = '0;
        rst = 1'b1;
        mode_m = 8'($urandom(40));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h9C, 8'h82);
        rd(8'h9F, 8'hFF);
        rd(8'h9E, 8'hFF);
        chk("response mode", 16'h2, {14'h0, resp});
        $display("reset values done");
        for (int i = 0; i < 8; i++)
        begin
            d = 8'h80 | 8'($urandom);
            if (i < 4)
                d[1:0] = 2'(i);
            wr(8'h9C, d);
            mode_m = 8'h80 | (d & 8'h33);
            idle(1);
            chk("response mode", {14'h0, d[1:0]}, {14'h0, resp});
            rd(8'h9C, mode_m);
        end
        $display("mode register done");
        wr(8'h9B, 8'h80);
        wr(8'h9A, 8'h80);
        for (int k = 0; k < 2; k++)
        begin
            for (int c = 0; c < 16; c++)
            begin
                p = c;
                n = 15 - c;
                wr(k ? 8'h9E : 8'h9F, {4'(n), 4'(p)});
                idle(1);
                chk("positive mux", mux_exp(p, 0), {pm[k], pi[k]});
                chk("negative mux", mux_exp(n, 1), {nm[k], ni[k]});
                chk("divider", {15'h0, p == 13 || n == 13}, {15'h0, half_on});
                chk("touch", {15'h0, (p == 12 && n < 11) || (n == 12 && p < 12)},
                    {15'h0, k ? touch_b : touch_a});
                rd(k ? 8'h9E : 8'h9F, {4'(n), 4'(p)});
            end
            wr(k ? 8'h9E : 8'h9F, 8'hFF);
        end
        $display("input select done");
        wr(8'h9C, 8'hA0);
        @(posedge ref_clk);
        comp_b_raw_out <= 1'b1;
        comp_a_raw_out <= 1'b1;
        idle(6);
        chk("irq", 16'h1, {15'h0, irq_b});
        chk("capture b", 16'h1, {15'h0, cap_b});
        chk("capture a", 16'h1, {15'h0, cap_a});
        rd(8'h9A, 8'hE0);
        wr(8'h9A, 8'h80);
        idle(1);
        chk("irq", 16'h0, {15'h0, irq_b});
        @(posedge ref_clk);
        comp_b_raw_out <= 1'b0;
        idle(6);
        chk("irq", 16'h0, {15'h0, irq_b});
        rd(8'h9A, 8'h90);
        wr(8'h9C, 8'h90);
        idle(1);
        chk("irq", 16'h1, {15'h0, irq_b});
        $display("edge flags done");
        wr(8'h9B, 8'h00);
        idle(1);
        chk("power a", 16'h0, {15'h0, a_on});
        chk("positive mux", 16'h0, {pm[0], pi[0]});
        chk("capture a", 16'h0, {15'h0, cap_a});
        $display("disable done");
        wr(8'h9C, 8'h80, 8'h01);
        rd(8'h9C, 8'h90);
        rd(8'h9C, 8'h00, 8'h01);
        rd(8'hA0, 8'h00);
        $display("decode done");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h9C, 8'h82);
        chk("irq", 16'h0, {15'h0, irq_b});
        $display("second reset done");
        end_sim();
    end
endmodule // comparator_mode_and_input_select_bench
`default_nettype wire
